// >>> src/srsbe_pkg.sv
/*
 * constants, state layout and memory carrier for the stack, rotate and
 * subtract-with-borrow execution block.
 * assumes a big-endian memory that stores the low bytes of wdata at the
 * given size and returns read data zero-extended in the low bits.
 */
package srsbe_pkg;
    localparam logic [15:0] OP_PUSH_CONDITION_FLAGS   = 16'h0002;
    localparam logic [15:0] OP_RET     = 16'hfffc;
    localparam logic [15:0] OP_EXT     = 16'h0007;
    localparam logic [7:0]  HI_PUSH32R = 8'h10;
    localparam logic [7:0]  HI_PUSH16R = 8'h16;
    localparam logic [7:0]  HI_PUSH8R  = 8'h14;
    localparam logic [7:0]  HI_PUSH32I = 8'h0d;
    localparam logic [7:0]  HI_PUSH16I = 8'h0c;
    localparam logic [7:0]  HI_PUSH8I  = 8'h0a;
    localparam logic [7:0]  HI_PMHI    = 8'h05;
    localparam logic [7:0]  HI_PMLO    = 8'h04;
    localparam logic [7:0]  HI_RLREG   = 8'hb7;
    localparam logic [7:0]  HI_SBCREG  = 8'ha1;
    localparam logic [7:0]  HI_SBCOFF  = 8'h79;
    localparam logic [3:0]  NIB_REGPSH = 4'hf;
    localparam logic [3:0]  NIB_RLIMM  = 4'hb;
    localparam logic [2:0]  RLIMM_SUB  = 3'h7;
    localparam logic [1:0]  SZ_BYTE    = 2'h0;
    localparam logic [1:0]  SZ_WORD    = 2'h1;
    localparam logic [1:0]  SZ_QUAD    = 2'h2;
    localparam logic [4:0]  SH_BYTE    = 5'h18;
    localparam logic [4:0]  SH_WORD    = 5'h10;
    localparam logic [2:0]  OFF_LDUB   = 3'h0;
    localparam logic [2:0]  OFF_LDSB   = 3'h1;
    localparam logic [2:0]  OFF_LDUW   = 3'h2;
    localparam logic [2:0]  OFF_LDSW   = 3'h3;
    localparam logic [2:0]  OFF_STB    = 3'h5;
    localparam logic [2:0]  OFF_STW    = 3'h6;
    localparam logic [3:0]  SP_IDX     = 4'hf;
    localparam logic [3:0]  HI_TOP     = 4'hf;
    localparam logic [3:0]  LO_TOP     = 4'h7;
    localparam logic [7:0]  PF_PAD     = 8'h00;
    localparam logic [31:0] PC_STEP    = 32'h2;
    localparam logic [31:0] STEP_B     = 32'h1;
    localparam logic [31:0] STEP_W     = 32'h2;
    localparam logic [31:0] STEP_Q     = 32'h4;
    localparam int FL_C = 7;
    localparam int FL_Z = 6;
    localparam int FL_S = 5;
    localparam int FL_V = 4;
    localparam int FL_B = 3;
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_OFFS  = 3'b001,
        ST_RD    = 3'b010,
        ST_WR    = 3'b011,
        ST_MULTI = 3'b100
    } srsbe_st_t;
    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } srsbe_mreq_t;
    typedef struct packed {
        srsbe_st_t        st;
        logic [15:0][31:0] rf;
        logic [31:0]      pc;
        logic [7:0]       flags;
        logic             pfx;
        logic             redirect;
        logic             isRet;
        logic             isMulti;
        logic             storeForm;
        logic [2:0]       offCode;
        logic [3:0]       rs;
        logic [3:0]       rd;
        logic [7:0]       mask;
        logic             hiHalf;
        logic [3:0]       idx;
        srsbe_mreq_t      mem;
        logic [31:0]      dbg;
    } srsbe_state_t;
    localparam srsbe_state_t STATE_RST = '0;
endpackage : srsbe_pkg

// >>> src/srsbe_exec.sv
/*
 * execution unit for pushes, return, rotate left and subtract-with-borrow.
 * assumes a fetch source handing one 16-bit word per valid/ready beat and a
 * memory answering each held request with a one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none
module srsbe_exec
    import srsbe_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    output logic             instrReady,
    output srsbe_mreq_t      memOut,
    input  wire logic        memAck,
    input  wire logic [31:0] memRdata,
    output logic [31:0]      programCounter,
    output logic             pcRedirect,
    output logic [31:0]      stackPointer,
    output logic [7:0]       condFlags,
    input  wire logic        setWe,
    input  wire logic [3:0]  setSel,
    input  wire logic [31:0] setData,
    input  wire logic [3:0]  dbgSel,
    output logic [31:0]      dbgData
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [35:0] sbc_calc(input logic [31:0] a,
                                             input logic [31:0] b,
                                             input logic        cin,
                                             input logic [1:0]  sz);
        logic [4:0]  sh;
        logic [31:0] aa;
        logic [31:0] bb;
        logic [32:0] s;
        sh = (sz == SZ_BYTE) ? SH_BYTE : ((sz == SZ_WORD) ? SH_WORD : 5'h00);
        aa = a << sh;
        bb = b << sh;
        s  = {1'b0, aa} + {1'b0, ~bb} + {32'h0, ~cin};
        // narrow forms leave ones below the operand when carry is set, so test the shifted result
        return {~s[32], (s[31:0] >> sh) == 32'h0, s[31],
                (aa[31] != bb[31]) && (s[31] != aa[31]), s[31:0] >> sh};
    endfunction : sbc_calc

    function automatic logic [31:0] ld_ext(input logic [31:0] v,
                                           input logic [2:0]  code);
        unique case (code)
            OFF_LDUB: return {24'h0, v[7:0]};
            OFF_LDSB: return {{24{v[7]}}, v[7:0]};
            OFF_LDUW: return {16'h0, v[15:0]};
            OFF_LDSW: return {{16{v[15]}}, v[15:0]};
            default:  return v;
        endcase
    endfunction : ld_ext

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    srsbe_state_t q;
    srsbe_state_t d;
    logic         take;
    logic [7:0]   hiB;
    logic [3:0]   wRs;
    logic [3:0]   wRd;
    logic         pushGo;
    logic [1:0]   pushSz;
    logic [31:0]  pushVal;
    logic [31:0]  pushStep;
    logic [31:0]  spNew;
    logic [4:0]   rlCnt;
    logic [31:0]  rlSrc;
    logic [63:0]  rlWide;
    logic [31:0]  rlRes;
    logic         rlC;
    logic [35:0]  sbcOut;
    logic [31:0]  baseAddr;
    logic [1:0]   offSz;
    logic [3:0]   multiReg;

    assign take           = instrValid && instrReady;
    assign hiB            = instrWord[15:8];
    assign wRs            = instrWord[7:4];
    assign wRd            = instrWord[3:0];
    assign instrReady     = (q.st == ST_FETCH) || (q.st == ST_OFFS);
    assign memOut         = q.mem;
    assign programCounter = q.pc;
    assign pcRedirect     = q.redirect;
    assign stackPointer   = q.rf[SP_IDX];
    assign condFlags      = q.flags;
    assign dbgData        = q.dbg;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d        = q;
        pushGo   = 1'b0;
        pushSz   = SZ_QUAD;
        pushVal  = 32'h0;
        pushStep = STEP_Q;
        spNew    = q.rf[SP_IDX];
        rlCnt    = 5'h00;
        rlSrc    = q.rf[wRd];
        rlWide   = 64'h0;
        rlRes    = 32'h0;
        rlC      = 1'b0;
        sbcOut   = 36'h0;
        baseAddr = 32'h0;
        offSz    = SZ_QUAD;
        multiReg = 4'h0;
        d.redirect = 1'b0;
        d.dbg      = q.rf[dbgSel];
        if (setWe) begin
            d.rf[setSel] = setData;
        end
        unique case (q.st)
            ST_FETCH: begin
                if (take) begin
                    d.pc  = q.pc + PC_STEP;
                    d.pfx = 1'b0;
                    if (instrWord == OP_PUSH_CONDITION_FLAGS) begin
                        pushGo  = 1'b1;
                        pushSz  = SZ_WORD;
                        pushVal = {16'h0, PF_PAD, q.flags};
                    end else if (instrWord == OP_EXT) begin
                        d.pfx = 1'b1;
                    end else if (instrWord == OP_RET) begin
                        d.isRet = 1'b1;
                        d.mem   = '{1'b1, 1'b0, SZ_QUAD, q.rf[SP_IDX], 32'h0};
                        d.st    = ST_RD;
                    end else if (wRd == NIB_REGPSH && hiB == HI_PUSH32R) begin
                        pushGo  = 1'b1;
                        pushVal = q.rf[wRs];
                    end else if (wRd == NIB_REGPSH && hiB == HI_PUSH16R) begin
                        pushGo  = 1'b1;
                        pushSz  = SZ_WORD;
                        pushVal = {16'h0, q.rf[wRs][15:0]};
                    end else if (wRd == NIB_REGPSH && hiB == HI_PUSH8R) begin
                        pushGo  = 1'b1;
                        pushSz  = SZ_BYTE;
                        pushVal = {24'h0, q.rf[wRs][7:0]};
                    end else if (hiB == HI_PUSH32I) begin
                        pushGo  = 1'b1;
                        pushVal = {{24{instrWord[7]}}, instrWord[7:0]};
                    end else if (hiB == HI_PUSH16I) begin
                        pushGo  = 1'b1;
                        pushSz  = SZ_WORD;
                        pushVal = {16'h0, {8{instrWord[7]}}, instrWord[7:0]};
                    end else if (hiB == HI_PUSH8I) begin
                        pushGo  = 1'b1;
                        pushSz  = SZ_BYTE;
                        pushVal = {24'h0, instrWord[7:0]};
                    end else if (hiB == HI_PMHI || hiB == HI_PMLO) begin
                        d.mask    = instrWord[7:0];
                        d.hiHalf  = (hiB == HI_PMHI);
                        d.idx     = 4'h0;
                        d.isMulti = 1'b1;
                        d.st      = ST_MULTI;
                    end else if (instrWord[15:12] == NIB_RLIMM &&
                                 instrWord[11:9] == RLIMM_SUB) begin
                        rlCnt = instrWord[8:4];
                    end else if (hiB == HI_RLREG) begin
                        rlCnt = q.rf[wRs][4:0];
                    end else if (hiB == HI_SBCREG && q.pfx) begin
                        sbcOut = sbc_calc(q.rf[wRd], q.rf[wRs], q.flags[FL_C], SZ_QUAD);
                        d.rf[wRd] = sbcOut[31:0];
                        // zero stays set only on zero result
                        d.flags[FL_C] = sbcOut[35];
                        d.flags[FL_Z] = sbcOut[34] && q.flags[FL_Z];
                        d.flags[FL_S] = sbcOut[33];
                        d.flags[FL_V] = sbcOut[32];
                        d.flags[FL_B] = 1'b0;
                    end else if (hiB == HI_SBCOFF && q.pfx) begin
                        d.rs = wRs;
                        d.rd = wRd;
                        d.st = ST_OFFS;
                    end
                    if ((instrWord[15:12] == NIB_RLIMM &&
                         instrWord[11:9] == RLIMM_SUB) || hiB == HI_RLREG) begin
                        rlWide = {rlSrc, rlSrc} << rlCnt;
                        rlRes  = rlWide[63:32];
                        rlC    = (rlCnt != 5'h00) && rlRes[0];
                        d.rf[wRd] = rlRes;
                        d.flags[FL_C] = rlC;
                        d.flags[FL_Z] = (rlRes == 32'h0);
                        d.flags[FL_S] = rlRes[31];
                        d.flags[FL_V] = rlC ^ rlRes[31];
                        d.flags[FL_B] = 1'b0;
                    end
                end
            end
            ST_OFFS: begin
                if (take) begin
                    d.pc        = q.pc + PC_STEP;
                    d.offCode   = instrWord[15:13];
                    d.storeForm = (instrWord[15:13] >= OFF_STB);
                    baseAddr    = (instrWord[15:13] >= OFF_STB) ? q.rf[q.rd] : q.rf[q.rs];
                    if (instrWord[15:13] <= OFF_LDSB || instrWord[15:13] == OFF_STB) begin
                        offSz = SZ_BYTE;
                    end else if (instrWord[15:13] <= OFF_LDSW ||
                                 instrWord[15:13] == OFF_STW) begin
                        offSz = SZ_WORD;
                    end
                    d.mem = '{1'b1, 1'b0, offSz,
                              baseAddr + {{19{instrWord[12]}}, instrWord[12:0]}, 32'h0};
                    d.st  = ST_RD;
                end
            end
            ST_RD: begin
                if (memAck) begin
                    d.mem.req = 1'b0;
                    d.st      = ST_FETCH;
                    if (q.isRet) begin
                        // new PC, stack up by four
                        d.pc         = memRdata;
                        d.rf[SP_IDX] = q.rf[SP_IDX] + STEP_Q;
                        d.redirect   = 1'b1;
                        d.isRet      = 1'b0;
                    end else begin
                        if (q.storeForm) begin
                            sbcOut = sbc_calc(memRdata, q.rf[q.rs], q.flags[FL_C],
                                              q.mem.size);
                            d.mem  = '{1'b1, 1'b1, q.mem.size, q.mem.addr, sbcOut[31:0]};
                            d.st   = ST_WR;
                        end else begin
                            sbcOut = sbc_calc(q.rf[q.rd], ld_ext(memRdata, q.offCode),
                                              q.flags[FL_C], SZ_QUAD);
                            d.rf[q.rd] = sbcOut[31:0];
                        end
                        // zero stays set only on zero result
                        d.flags[FL_C] = sbcOut[35];
                        d.flags[FL_Z] = sbcOut[34] && q.flags[FL_Z];
                        d.flags[FL_S] = sbcOut[33];
                        d.flags[FL_V] = sbcOut[32];
                        d.flags[FL_B] = 1'b0;
                    end
                end
            end
            ST_WR: begin
                if (memAck) begin
                    d.mem.req = 1'b0;
                    d.st      = q.isMulti ? ST_MULTI : ST_FETCH;
                end
            end
            ST_MULTI: begin
                if (q.idx[3]) begin
                    d.isMulti = 1'b0;
                    d.st      = ST_FETCH;
                end else begin
                    d.idx = q.idx + 4'h1;
                    // object mask bit i is register top minus i
                    multiReg = (q.hiHalf ? HI_TOP : LO_TOP) - q.idx;
                    if (q.mask[q.idx[2:0]]) begin
                        pushGo  = 1'b1;
                        pushVal = q.rf[multiReg];
                    end
                end
            end
            default: begin
                d.st = ST_FETCH;
            end
        endcase
        if (pushGo) begin
            pushStep = (pushSz == SZ_BYTE) ? STEP_B :
                       ((pushSz == SZ_WORD) ? STEP_W : STEP_Q);
            spNew        = q.rf[SP_IDX] - pushStep;
            d.rf[SP_IDX] = spNew;
            d.mem        = '{1'b1, 1'b1, pushSz, spNew, pushVal};
            d.st         = ST_WR;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= STATE_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_take(logic [15:0] w);
        ce && take && q.st == ST_FETCH && instrWord == w;
    endsequence

    sequence s_take_hi(logic [7:0] h);
        ce && take && q.st == ST_FETCH && hiB == h && !q.pfx;
    endsequence

    a_push_condition_flags_stack: assert property (s_take(OP_PUSH_CONDITION_FLAGS) |=>
        stackPointer == $past(stackPointer) - STEP_W && memOut.we &&
        memOut.wdata == {16'h0, PF_PAD, $past(condFlags)})
        else $error("flags push stack or data wrong");

    a_push_noflag: assert property ((q.st == ST_WR || q.st == ST_MULTI)
        && !q.storeForm |=> $stable(condFlags))
        else $error("flags changed during push");

    a_push8_step: assert property (s_take_hi(HI_PUSH8I) |=>
        stackPointer == $past(stackPointer) - STEP_B && memOut.size == SZ_BYTE)
        else $error("byte push step wrong");

    a_push32_sext: assert property (s_take_hi(HI_PUSH32I) |=>
        memOut.wdata == {{24{$past(instrWord[7])}}, $past(instrWord[7:0])} &&
        stackPointer == $past(stackPointer) - STEP_Q)
        else $error("32-bit immediate push wrong");

    a_multi_step: assert property (ce && q.st == ST_MULTI && !q.idx[3] &&
        q.mask[q.idx[2:0]] |=> memOut.req && memOut.we &&
        memOut.addr == stackPointer && stackPointer == $past(stackPointer) - STEP_Q)
        else $error("multi-push step wrong");

    a_ret_load: assert property (ce && q.st == ST_RD && q.isRet && memAck |=>
        pcRedirect && programCounter == $past(memRdata) &&
        stackPointer == $past(stackPointer) + STEP_Q ##1 !pcRedirect)
        else $error("return did not reload pc");

    a_rl_flags: assert property (s_take_hi(HI_RLREG) |=>
        !condFlags[FL_B] && condFlags[FL_V] == (condFlags[FL_C] ^ condFlags[FL_S]))
        else $error("rotate flags wrong");

    a_sbc_zero: assert property (ce && take && q.st == ST_FETCH && q.pfx &&
        hiB == HI_SBCREG && !condFlags[FL_Z] |=> !condFlags[FL_Z])
        else $error("borrow subtract raised zero");

    a_sbc_prefix: assert property (s_take_hi(HI_SBCREG) |=>
        $stable(condFlags))
        else $error("subtract ran without prefix");
endmodule : srsbe_exec
`default_nettype wire

// >>> bench/srsbe_mem_model.sv
/*
 * byte memory for the stack and operands, big-endian, slow and prompt acks.
 * assumes the unit holds each request until its ack.
 */
`timescale 1ns/1ps
`default_nettype none
module srsbe_mem_model
    import srsbe_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire srsbe_mreq_t memOut,
    output logic             memAck,
    output logic [31:0]      memRdata
);
    logic [7:0]  mem [logic [31:0]] = '{default: 8'h00};
    logic [31:0] rdQ;
    logic [31:0] tmp;
    int          waitQ;
    int          dly;
    // outside an ack the data lines show garbage
    assign memRdata = memAck ? rdQ : ~rdQ;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            memAck <= 1'b0;
            rdQ    <= 32'h0;
            waitQ  <= 0;
            dly    <= 0;
        end else if (memAck || !memOut.req) begin
            memAck <= 1'b0;
            waitQ  <= dly % 3;
            dly    <= dly + 1;
        end else if (waitQ != 0) begin
            waitQ <= waitQ - 1;
        end else begin
            tmp = 32'h0;
            for (int j = 0; j < (1 << memOut.size); j++) begin
                if (memOut.we)
                    mem[memOut.addr + j] = memOut.wdata >> (8 * ((1 << memOut.size) - 1 - j));
                tmp = {tmp[23:0], mem[memOut.addr + j]};
            end
            rdQ    <= tmp;
            memAck <= 1'b1;
        end
    end
endmodule : srsbe_mem_model
`default_nettype wire

// >>> bench/stack_rotate_subborrow_exec_tb.sv
/*
 * self-checking bench: random rotate, push and borrow-subtract traffic.
 * assumes the memory model answers every request.
 */
`timescale 1ns/1ps
`default_nettype none
module stack_rotate_subborrow_exec_tb
    import srsbe_pkg::*;
;
    logic core_clk, nrst, ce, instrValid, instrReady, memAck, pcRedirect, setWe, cin;
    logic [15:0] instrWord;
    logic [31:0] memRdata, programCounter, stackPointer, setData, dbgData, a, b, r, v, e, sp;
    logic [7:0]  condFlags, fl, fe;
    logic [3:0]  setSel, dbgSel;
    srsbe_mreq_t memOut;
    int          errors, tests_run, seed, i, k, nb;
    logic [7:0]  hiT [6] = '{8'h0a, 8'h0c, 8'h0d, 8'h14, 8'h16, 8'h10};
    logic [3:0]  mp [5] = '{4'hd, 4'h7, 4'h6, 4'h5, 4'h0};
    srsbe_exec uut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .instrValid(instrValid),
        .instrWord(instrWord), .instrReady(instrReady), .memOut(memOut), .memAck(memAck),
        .memRdata(memRdata), .programCounter(programCounter), .pcRedirect(pcRedirect),
        .stackPointer(stackPointer), .condFlags(condFlags), .setWe(setWe), .setSel(setSel),
        .setData(setData), .dbgSel(dbgSel), .dbgData(dbgData));
    srsbe_mem_model mdl (.core_clk(core_clk), .nrst(nrst), .memOut(memOut),
        .memAck(memAck), .memRdata(memRdata));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function logic [31:0] rotl(input logic [31:0] x, input logic [4:0] c);
        rotl = (x << c) | (x >> (6'd32 - c));
    endfunction : rotl
    function logic [31:0] mrd(input logic [31:0] ad, input int n);
        mrd = 32'h0;
        for (int j = 0; j < n; j++) mrd = {mrd[23:0], mdl.mem[ad + j]};
    endfunction : mrd
    task results;
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task tick;
        @(posedge core_clk);
        #1;
    endtask : tick
    task setr(input logic [3:0] s, input logic [31:0] d);
        setSel = s;
        setData = d;
        setWe = 1'b1;
        tick();
        setWe = 1'b0;
        tick();
    endtask : setr
    task getr(input logic [3:0] s, output logic [31:0] d);
        dbgSel = s;
        tick();
        d = dbgData;
    endtask : getr
    task automatic ins(input logic [15:0] w);
        int n = 0;
        instrWord = w;
        instrValid = 1'b1;
        tick();
        instrValid = 1'b0;
        do begin
            tick();
            n++;
        end while (instrReady !== 1'b1 && n < 500);
        if (n >= 500) errors++;
    endtask : ins
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #2000000;
        errors++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, instrValid, instrWord, setWe, setSel, setData, dbgSel} = '0;
        ce = 1'b1;
        seed = 26308;
        repeat (6) @(posedge core_clk);
        #1 nrst = 1'b1;
        chk(programCounter, 32'h0);
        chk(instrReady, 32'h1);
        sp = 32'h1000;
        setr(4'hf, sp);
        for (i = 0; i < 8; i++) begin
            a = (i == 0) ? 32'h0 : $random(seed);
            b = (i == 0) ? 32'h0 : $random(seed);
            r = rotl(a, b[4:0]);
            fl = {(b[4:0] != 5'h0) & r[0], r == 32'h0, r[31], 5'h00};
            setr(4'h1, a);
            setr(4'h2, b);
            if (i[0]) ins({4'hb, 3'h7, b[4:0], 4'h1});
            else ins({8'hb7, 4'h2, 4'h1});
            getr(4'h1, e);
            chk(e, r); // rotated value
            getr(4'h2, e);
            chk(e, b); // source kept
            chk(condFlags & 8'he8, fl); // rotate flags
            ins(OP_PUSH_CONDITION_FLAGS);
            sp = sp - 32'h2;
            chk(stackPointer, sp); // stack step
            chk(mrd(sp, 2) & 32'hffe8, fl); // flags byte order
            for (k = 0; k < 6; k++) begin
                nb = 1 << (k % 3);
                v = (k < 3) ? {{24{a[7]}}, a[7:0]} : r;
                ins((k < 3) ? {hiT[k], a[7:0]} : {hiT[k], 8'h1f});
                sp = sp - nb;
                chk(stackPointer, sp); // stack step
                chk(mrd(sp, nb), v & ~(32'hffffffff << (8 * nb))); // value
                chk(condFlags & 8'he8, fl); // flags kept
            end
            cin = fl[7];
            if (i == 1) b = r - cin;
            setr(4'h2, b);
            ins(OP_EXT);
            ins({8'ha1, 4'h2, 4'h1});
            v = r - b - cin;
            fe = {({1'b0, r} < {1'b0, b} + 33'(cin)), fl[6] & (v == 32'h0), v[31], 5'h00};
            getr(4'h1, e);
            chk(e, v); // difference
            getr(4'h2, e);
            chk(e, b); // source kept
            chk(condFlags & 8'he8, fe); // flags
            ins({8'ha1, 4'h2, 4'h1});
            getr(4'h1, e);
            chk(e, v); // no prefix, no effect
        end
        for (k = 0; k < 2; k++) begin
            cin = condFlags[7];
            fl = condFlags;
            setr(4'h3, 32'h2000);
            setr(4'h4, b);
            for (nb = 0; nb < 4; nb++) mdl.mem[32'h2004 + nb] = a[31 - 8 * nb -: 8];
            ins(OP_EXT);
            ins({8'h79, k ? 8'h34 : 8'h43});
            ins(k ? 16'h2004 : 16'ha004);
            e = k ? {{24{a[31]}}, a[31:24]} : {24'h0, a[31:24]};
            v = k ? b - e - cin : (e - b - cin) & 32'hff;
            fe = k ? {({1'b0, b} < {1'b0, e} + 33'(cin)), fl[6] & (v == 32'h0), v[31], 5'h00}
                   : {(e < {24'h0, b[7:0]} + 32'(cin)), fl[6] & (v == 32'h0), v[7], 5'h00};
            getr(4'h4, r);
            chk(k ? r : {24'h0, mdl.mem[32'h2004]}, v); // memory form result
            chk(condFlags & 8'he8, fe); // byte-width flags for the store form, 32-bit flags for the load form
        end
        for (k = 0; k < 5; k++) setr(mp[k], {8{mp[k]}});
        ins(16'h0504);
        ins(16'h0487);
        for (k = 0; k < 5; k++) begin
            sp = sp - 32'h4;
            chk(mrd(sp, 4), {8{mp[k]}}); // order
        end
        chk(stackPointer, sp); // stack step
        e = $random(seed) & 32'hfffffffe;
        for (k = 0; k < 4; k++) mdl.mem[sp + k] = e[31 - 8 * k -: 8];
        ins(OP_RET);
        chk(pcRedirect, 32'h1); // redirect pulse
        chk(programCounter, e); // new pc
        chk(stackPointer, sp + 32'h4); // stack step
        results();
    end
endmodule : stack_rotate_subborrow_exec_tb
`default_nettype wire
